// ### dv/descriptor_pointer_registers_bench.sv
// register-level tests of the descriptor pointer bank
`timescale 1ns/1ps
`include "descriptor_pointer_consts.svh"
module descriptor_pointer_registers_bench;
	logic clk = 0, resetn = 0, soft_reset = 0, cyc = 0, stb = 0, we = 0;
	logic go = 0, adv = 0, ack, packet_done, fetch, flag;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, rdat;
	logic [15:0] words = 16'h0000, rem, rd;
	descriptor_pointer_pkg::resource_sel_t rsel =
		descriptor_pointer_pkg::res_sel_start;
	descriptor_pointer_pkg::dma_addresses_t dma;
	logic [15:0] rv [4] = '{16'h1001, 16'h2003, 16'h3005, 16'h3005};
	int err_total = 0, check_count = 0, cyc_n = 0, fetch_n = 0;
	descriptor_pointer_registers dut (.clk(clk), .resetn(resetn),
		.soft_reset(soft_reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .packet_done(packet_done),
		.remaining_buffer_word_count(rem), .resource_sel(rsel),
		.transmit_advance(1'b0), .transmit_next(16'h0000),
		.receive_advance(1'b0), .receive_next(16'h0000),
		.resource_read_advance(adv), .dma_addr(dma),
		.transmit_list_last(), .receive_list_last(),
		.resource_empty(), .fetch_resource(fetch),
		.last_packet_in_buffer_flag(flag));
	receive_engine_model rx (.clk(clk), .resetn(resetn), .go(go),
		.words(words), .packet_done(packet_done),
		.remaining_buffer_word_count(rem));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one classic cycle; holds everything until ack is seen at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3;
		dat <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat[15:0];
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic packet(input logic [15:0] n);
		@(posedge clk);
		go <= 1'b1; words <= n;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic pointers_kept(input string when);
		bus(0, `OFS_CURRENT_TRANSMIT_POINTER, 16'h0000);
		check({when, " cur tx"}, rd, 16'h1235);
		bus(0, `OFS_UPPER_RECEIVE_POINTER, 16'h0000);
		check({when, " up rx"}, rd, 16'h8765);
		bus(0, `OFS_RESOURCE_END_ADDRESS, 16'h0000);
		check({when, " res end"}, rd, 16'h2002);
	endtask
	// counts resource fetch pulses as the dma would see them
	always @(posedge clk) begin
		if (fetch === 1'b1)
			fetch_n++;
	end
	// hang guard: the whole run needs under two hundred cycles
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n > 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		bus(0, `OFS_END_OF_BUFFER_COUNT, 16'h0000);
		check("eob reset", rd, 16'h02f8);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq reset", rd, 16'h0000);
		bus(0, 8'h30, 16'h0000);
		check("unmapped", rd, 16'h0000);
		$display("reset values done");
		bus(1, `OFS_UPPER_TRANSMIT_POINTER, 16'habcd);
		bus(1, `OFS_CURRENT_TRANSMIT_POINTER, 16'h1235);
		bus(1, `OFS_UPPER_RECEIVE_POINTER, 16'h8765);
		bus(1, `OFS_CURRENT_RECEIVE_POINTER, 16'h4320);
		bus(0, `OFS_CURRENT_TRANSMIT_POINTER, 16'h0000);
		check("cur tx", rd, 16'h1235);
		check("tx addr", dma.transmit_desc, 32'habcd_1234);
		check("tx last", dut.transmit_list_last, 1'b1);
		check("rx addr", dma.receive_desc, 32'h8765_4320);
		check("rx last", dut.receive_list_last, 1'b0);
		bus(1, `OFS_UPPER_RESOURCE_ADDRESS, 16'h00c0);
		for (int i = 0; i < 4; i++)
			bus(1, `OFS_RESOURCE_START_ADDRESS + 8'(4 * i), rv[i]);
		for (int i = 0; i < 4; i++) begin
			bus(0, `OFS_RESOURCE_START_ADDRESS + 8'(4 * i), 16'h0000);
			check("res read", rd, rv[i] & 16'hfffe);
			rsel <= descriptor_pointer_pkg::resource_sel_t'(i);
			@(posedge clk);
			check("res addr", dma.resource,
				{16'h00c0, rv[i] & 16'hfffe});
		end
		check("res empty", dut.resource_empty, 1'b1);
		@(posedge clk) adv <= 1'b1;
		@(posedge clk) adv <= 1'b0;
		@(posedge clk);
		check("res not empty", dut.resource_empty, 1'b0);
		bus(0, `OFS_RESOURCE_READ_POINTER, 16'h0000);
		check("res advance", rd, 16'h3006);
		$display("pointer tests done");
		bus(1, `OFS_END_OF_BUFFER_COUNT, 16'h0010);
		packet(16'h0010);
		check("same buffer", flag, 1'b0);
		check("no fetch", fetch_n, 0);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq pkt", rd, 16'h0001);
		packet(16'h000f);
		check("new buffer", flag, 1'b1);
		check("fetch", fetch_n, 1);
		bus(0, `OFS_RECEIVE_CONTROL, 16'h0000);
		check("ctrl flag", rd[0], 1'b1);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq buf", rd, 16'h0100);
		$display("packet tests done");
		@(posedge clk) soft_reset <= 1'b1;
		@(posedge clk) soft_reset <= 1'b0;
		pointers_kept("soft");
		check("soft flag", flag, 1'b0);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq soft", rd, 16'h0100);
		bus(1, `OFS_END_OF_BUFFER_COUNT, 16'h0123);
		bus(0, `OFS_END_OF_BUFFER_COUNT, 16'h0000);
		check("eob write", rd, 16'h0123);
		@(posedge clk) resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		pointers_kept("hard");
		bus(0, `OFS_END_OF_BUFFER_COUNT, 16'h0000);
		check("eob hard", rd, 16'h02f8);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq hard", rd, 16'h0000);
		packet(16'h0400);
		bus(1, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq zero", rd, 16'h0000);
		bus(1, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'hffff);
		packet(16'h0400);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq pkt wrap", rd, 16'hff00);
		packet(16'h0000);
		bus(0, `OFS_RECEIVE_SEQUENCE_COUNTER, 16'h0000);
		check("seq buf wrap", rd, 16'h0000);
		check("fetch again", fetch_n, 2);
		check("flag set", flag, 1'b1);
		bus(1, `OFS_RECEIVE_CONTROL, 16'h0001);
		bus(0, `OFS_RECEIVE_CONTROL, 16'h0000);
		check("flag cleared", rd[0], 1'b0);
		$display("reset tests done");
		report_and_stop();
	end
endmodule

// ### dv/descriptor_pointer_registers_sva.sv
// bus, address and packet-event checks for the pointer bank
`timescale 1ns/1ps
module descriptor_pointer_checker #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic soft_reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic packet_done,
	input wire descriptor_pointer_pkg::dma_addresses_t dma_addr,
	input wire logic fetch_resource,
	input wire logic last_packet_in_buffer_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// a request not yet answered, then a one-cycle answer
	sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence ack_s; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
	ack_answer_a: assert property (req_s |-> ack_s)
		else $error("bus request not answered in one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	word_align_a: assert property (dma_addr.transmit_desc[0] == 1'b0 &&
		dma_addr.receive_desc[0] == 1'b0 && dma_addr.resource[0] == 1'b0)
		else $error("dma address bit 0 set");
	// upper halves only move on a bus write, never on a reset
	tx_upper_a: assert property (!$stable(dma_addr.transmit_desc[31:16])
		|-> wb_ack_o && $past(wb_we_i))
		else $error("upper transmit half changed without a write");
	rx_upper_a: assert property (!$stable(dma_addr.receive_desc[31:16])
		|-> wb_ack_o && $past(wb_we_i))
		else $error("upper receive half changed without a write");
	fetch_cause_a: assert property (fetch_resource |-> $past(packet_done))
		else $error("resource fetch without a packet end");
	fetch_flag_a: assert property (fetch_resource |->
		last_packet_in_buffer_flag && !$past(fetch_resource))
		else $error("fetch not a pulse with the flag");
	flag_rise_a: assert property ($rose(last_packet_in_buffer_flag)
		|-> fetch_resource)
		else $error("last packet flag rose without a fetch");
	flag_soft_a: assert property (soft_reset && !packet_done
		|=> !last_packet_in_buffer_flag)
		else $error("soft reset left the last packet flag");
endmodule
bind descriptor_pointer_registers descriptor_pointer_checker #(
	.ADDR_W(ADDR_W)) chk (.*);

// ### dv/receive_engine_model.sv
// receive side stand-in: reports packet ends with the words left
`timescale 1ns/1ps
module receive_engine_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic go,
	input wire logic [15:0] words,
	output logic packet_done,
	output logic [15:0] remaining_buffer_word_count
);
	// count is only valid beside packet_done; otherwise it toggles
	always_ff @(posedge clk) begin
		if (!resetn) begin
			packet_done <= 1'b0;
			remaining_buffer_word_count <= 16'h0000;
		end else begin
			packet_done <= go;
			remaining_buffer_word_count <= go ? words :
				~remaining_buffer_word_count;
		end
	end
endmodule

// ### logic/descriptor_pointer_consts.svh
// register offsets, reset values and field positions of the pointer bank
`ifndef DESCRIPTOR_POINTER_CONSTS_SVH
`define DESCRIPTOR_POINTER_CONSTS_SVH

`define OFS_UPPER_TRANSMIT_POINTER 8'h00
`define OFS_CURRENT_TRANSMIT_POINTER 8'h04
`define OFS_UPPER_RECEIVE_POINTER 8'h08
`define OFS_CURRENT_RECEIVE_POINTER 8'h0c
`define OFS_END_OF_BUFFER_COUNT 8'h10
`define OFS_UPPER_RESOURCE_ADDRESS 8'h14
`define OFS_RESOURCE_START_ADDRESS 8'h18
`define OFS_RESOURCE_END_ADDRESS 8'h1c
`define OFS_RESOURCE_READ_POINTER 8'h20
`define OFS_RESOURCE_WRITE_POINTER 8'h24
`define OFS_RECEIVE_SEQUENCE_COUNTER 8'h28
`define OFS_RECEIVE_CONTROL 8'h2c

`define RST_END_OF_BUFFER_COUNT 16'h02f8
`define RST_RECEIVE_SEQUENCE_COUNTER 16'h0000
`define LIST_LAST_BIT 0
`define LAST_PACKET_BIT 0
`define BUFFER_SEQ_LSB 8
`define PACKET_SEQ_LSB 0

`endif

// ### logic/descriptor_pointer_pkg.sv
// types shared by the descriptor pointer bank
package descriptor_pointer_pkg;
	// which half-address register forms the resource area address
	typedef enum logic [1:0] {
		res_sel_start,
		res_sel_end,
		res_sel_read,
		res_sel_write
	} resource_sel_t;

	// receive sequence register layout
	typedef struct packed {
		logic [7:0] buffer_seq;
		logic [7:0] packet_seq;
	} receive_sequence_t;

	// joined 32-bit addresses handed to the dma
	typedef struct packed {
		logic [31:0] transmit_desc;
		logic [31:0] receive_desc;
		logic [31:0] resource;
	} dma_addresses_t;
endpackage

// ### logic/descriptor_pointer_registers.sv
// pointer and count registers used by the network controller dma
`timescale 1ns/1ps
`include "descriptor_pointer_consts.svh"

// Functional notes
// - upper transmit pointer holds A31:16, joined with current transmit pointer
// - current transmit pointer holds A15:1; bit 0 is the list-last flag
// - soft reset keeps all pointers; hard reset changes only count, sequence, last-packet flag, fetch request and bus ack/read data
// - upper receive pointer holds A31:16, joined with current receive pointer
// - joined receive address points at descriptor; current receive pointer bit 0 is list-last flag
// - count at or below remaining words keeps next packet in same buffer
// - count above remaining words sets last-packet flag and fetches resource
// - hard reset loads end-of-buffer count with 760 words
// - resource address joins upper resource bits with one of four registers
// - resource start holds A15:1; resource registers read bit 0 as zero
// - resource end holds A15:1, joined with upper resource address
// - read pointer holds A15:1 of next resource descriptor to fetch
// - write pointer holds A15:1 of next free resource location
// - sequence register: buffer number 15:8, packet number 7:0, both mod 256
// - new buffer clears packet number and increments buffer number
// - sequence clears on hard reset or zero write; soft reset keeps it
module descriptor_pointer_registers #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic soft_reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic packet_done,
	input wire logic [15:0] remaining_buffer_word_count,
	input wire descriptor_pointer_pkg::resource_sel_t resource_sel,
	input wire logic transmit_advance,
	input wire logic [15:0] transmit_next,
	input wire logic receive_advance,
	input wire logic [15:0] receive_next,
	input wire logic resource_read_advance,
	output descriptor_pointer_pkg::dma_addresses_t dma_addr,
	output logic transmit_list_last,
	output logic receive_list_last,
	output logic resource_empty,
	output logic fetch_resource,
	output logic last_packet_in_buffer_flag
);

	logic [15:0] upper_transmit_pointer_ff;
	logic [15:0] current_transmit_pointer_ff;
	logic [15:0] upper_receive_pointer_ff;
	logic [15:0] current_receive_pointer_ff;
	logic [15:0] end_of_buffer_count_ff;
	logic [15:0] upper_resource_address_ff;
	logic [14:0] resource_start_address_ff;
	logic [14:0] resource_end_address_ff;
	logic [14:0] resource_read_pointer_ff;
	logic [14:0] resource_write_pointer_ff;
	descriptor_pointer_pkg::receive_sequence_t receive_sequence_counter_ff;
	logic last_packet_ff;
	logic fetch_resource_ff;
	logic wb_ack_ff;
	logic [31:0] wb_dat_ff;
	logic [15:0] wdata;
	logic access;
	logic wr_en;
	logic lo_en;
	logic hi_en;
	logic new_buffer;
	logic [14:0] resource_low;
	logic wr_upper_tx;
	logic wr_current_tx;
	logic wr_upper_rx;
	logic wr_current_rx;
	logic wr_eob_count;
	logic wr_upper_res;
	logic wr_res_start;
	logic wr_res_end;
	logic wr_res_read;
	logic wr_res_write;
	logic wr_sequence;
	logic clear_last_packet;

	// single-cycle slave: answer one edge after the request, drop next cycle
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_ff;
	assign wr_en = access && wb_we_i;
	assign lo_en = wb_sel_i[0];
	assign hi_en = wb_sel_i[1];
	assign wdata = wb_dat_i[15:0];

	// one write strobe per register keeps each register process small;
	// a write lands at the edge that takes the request and raises ack
	// transmit pointers
	assign wr_upper_tx = wr_en &&
		(wb_adr_i == `OFS_UPPER_TRANSMIT_POINTER);
	assign wr_current_tx = wr_en &&
		(wb_adr_i == `OFS_CURRENT_TRANSMIT_POINTER);
	// receive pointers and the end-of-buffer count
	assign wr_upper_rx = wr_en &&
		(wb_adr_i == `OFS_UPPER_RECEIVE_POINTER);
	assign wr_current_rx = wr_en &&
		(wb_adr_i == `OFS_CURRENT_RECEIVE_POINTER);
	assign wr_eob_count = wr_en &&
		(wb_adr_i == `OFS_END_OF_BUFFER_COUNT);
	// resource area registers
	assign wr_upper_res = wr_en &&
		(wb_adr_i == `OFS_UPPER_RESOURCE_ADDRESS);
	assign wr_res_start = wr_en &&
		(wb_adr_i == `OFS_RESOURCE_START_ADDRESS);
	assign wr_res_end = wr_en &&
		(wb_adr_i == `OFS_RESOURCE_END_ADDRESS);
	assign wr_res_read = wr_en &&
		(wb_adr_i == `OFS_RESOURCE_READ_POINTER);
	assign wr_res_write = wr_en &&
		(wb_adr_i == `OFS_RESOURCE_WRITE_POINTER);
	// sequence counter and the write-one-to-clear flag
	assign wr_sequence = wr_en &&
		(wb_adr_i == `OFS_RECEIVE_SEQUENCE_COUNTER);
	assign clear_last_packet = wr_en &&
		(wb_adr_i == `OFS_RECEIVE_CONTROL) && lo_en &&
		wdata[`LAST_PACKET_BIT];

	// end of packet with too few words left forces a new buffer
	assign new_buffer = packet_done &&
		(end_of_buffer_count_ff > remaining_buffer_word_count);

	// byte-lane merge for the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic lo, input logic hi);
		merge16 = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
	endfunction

	// same merge for the 15-bit registers that keep only A15:1
	function automatic logic [14:0] merge15(input logic [14:0] old,
		input logic [15:0] nw, input logic lo, input logic hi);
		merge15 = {hi ? nw[15:8] : old[14:7], lo ? nw[7:1] : old[6:0]};
	endfunction

	// ack flop; soft reset does not disturb the bus
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack_ff <= 1'b0;
		end else begin
			wb_ack_ff <= access;
		end
	end

	// upper transmit half; neither reset touches any pointer register,
	// so these flops carry no reset term and read unknown until written
	always_ff @(posedge clk) begin
		if (wr_upper_tx) begin
			upper_transmit_pointer_ff <= merge16(upper_transmit_pointer_ff,
				wdata, lo_en, hi_en);
		end
	end

	// current transmit pointer; a software write beats a dma advance
	always_ff @(posedge clk) begin
		if (wr_current_tx) begin
			current_transmit_pointer_ff <= merge16(
				current_transmit_pointer_ff, wdata, lo_en, hi_en);
		end else if (transmit_advance) begin
			current_transmit_pointer_ff <= transmit_next;
		end
	end

	// upper receive half, written only by software
	always_ff @(posedge clk) begin
		if (wr_upper_rx) begin
			upper_receive_pointer_ff <= merge16(upper_receive_pointer_ff,
				wdata, lo_en, hi_en);
		end
	end

	// current receive pointer; a software write beats a dma advance
	always_ff @(posedge clk) begin
		if (wr_current_rx) begin
			current_receive_pointer_ff <= merge16(
				current_receive_pointer_ff, wdata, lo_en, hi_en);
		end else if (receive_advance) begin
			current_receive_pointer_ff <= receive_next;
		end
	end

	// upper resource half shared by all four resource registers
	always_ff @(posedge clk) begin
		if (wr_upper_res) begin
			upper_resource_address_ff <= merge16(upper_resource_address_ff,
				wdata, lo_en, hi_en);
		end
	end

	// resource registers keep only A15:1, so bit 0 costs no flop
	always_ff @(posedge clk) begin
		if (wr_res_start) begin
			resource_start_address_ff <= merge15(
				resource_start_address_ff, wdata, lo_en, hi_en);
		end
	end

	// ring end; the read pointer wraps here
	always_ff @(posedge clk) begin
		if (wr_res_end) begin
			resource_end_address_ff <= merge15(
				resource_end_address_ff, wdata, lo_en, hi_en);
		end
	end

	// read pointer: software load beats an advance in the same cycle
	always_ff @(posedge clk) begin
		if (wr_res_read) begin
			resource_read_pointer_ff <= merge15(
				resource_read_pointer_ff, wdata, lo_en, hi_en);
		end else if (resource_read_advance) begin
			// wrap from end back to start of the resource ring
			if (resource_read_pointer_ff == resource_end_address_ff) begin
				resource_read_pointer_ff <= resource_start_address_ff;
			end else begin
				resource_read_pointer_ff <= resource_read_pointer_ff +
					15'h0001;
			end
		end
	end

	// write pointer moves only when software adds descriptors
	always_ff @(posedge clk) begin
		if (wr_res_write) begin
			resource_write_pointer_ff <= merge15(
				resource_write_pointer_ff, wdata, lo_en, hi_en);
		end
	end

	// end-of-buffer count: hard reset value, untouched by soft reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			end_of_buffer_count_ff <= `RST_END_OF_BUFFER_COUNT;
		end else if (wr_eob_count) begin
			end_of_buffer_count_ff <= merge16(end_of_buffer_count_ff,
				wdata, lo_en, hi_en);
		end
	end

	// sequence counters; a software write takes priority over a packet
	always_ff @(posedge clk) begin
		if (!resetn) begin
			receive_sequence_counter_ff <=
				`RST_RECEIVE_SEQUENCE_COUNTER;
		end else if (wr_sequence) begin
			receive_sequence_counter_ff <= merge16(
				receive_sequence_counter_ff, wdata, lo_en, hi_en);
		end else if (new_buffer) begin
			receive_sequence_counter_ff.packet_seq <= 8'h00;
			receive_sequence_counter_ff.buffer_seq <=
				receive_sequence_counter_ff.buffer_seq + 8'h01;
		end else if (packet_done) begin
			receive_sequence_counter_ff.packet_seq <=
				receive_sequence_counter_ff.packet_seq + 8'h01;
		end
	end

	// last-packet flag: a new-buffer event wins over any clear in its
	// cycle, soft reset and a write of one included, so no event is lost
	always_ff @(posedge clk) begin
		if (!resetn) begin
			last_packet_ff <= 1'b0;
		end else if (new_buffer) begin
			last_packet_ff <= 1'b1;
		end else if (soft_reset || clear_last_packet) begin
			last_packet_ff <= 1'b0;
		end else if (packet_done) begin
			last_packet_ff <= 1'b0;
		end
	end

	// one-cycle request to fetch the next resource descriptor
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fetch_resource_ff <= 1'b0;
		end else begin
			fetch_resource_ff <= new_buffer;
		end
	end

	// read mux; reserved and unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_dat_ff <= 32'h0000_0000;
		end else if (access && !wb_we_i) begin
			case (wb_adr_i)
			`OFS_UPPER_TRANSMIT_POINTER: begin
				wb_dat_ff <= {16'h0000, upper_transmit_pointer_ff};
			end
			`OFS_CURRENT_TRANSMIT_POINTER: begin
				wb_dat_ff <= {16'h0000, current_transmit_pointer_ff};
			end
			`OFS_UPPER_RECEIVE_POINTER: begin
				wb_dat_ff <= {16'h0000, upper_receive_pointer_ff};
			end
			`OFS_CURRENT_RECEIVE_POINTER: begin
				wb_dat_ff <= {16'h0000, current_receive_pointer_ff};
			end
			`OFS_END_OF_BUFFER_COUNT: begin
				wb_dat_ff <= {16'h0000, end_of_buffer_count_ff};
			end
			`OFS_UPPER_RESOURCE_ADDRESS: begin
				wb_dat_ff <= {16'h0000, upper_resource_address_ff};
			end
			`OFS_RESOURCE_START_ADDRESS: begin
				wb_dat_ff <= {16'h0000, resource_start_address_ff,
					1'b0};
			end
			`OFS_RESOURCE_END_ADDRESS: begin
				wb_dat_ff <= {16'h0000, resource_end_address_ff, 1'b0};
			end
			`OFS_RESOURCE_READ_POINTER: begin
				wb_dat_ff <= {16'h0000, resource_read_pointer_ff, 1'b0};
			end
			`OFS_RESOURCE_WRITE_POINTER: begin
				wb_dat_ff <= {16'h0000, resource_write_pointer_ff, 1'b0};
			end
			`OFS_RECEIVE_SEQUENCE_COUNTER: begin
				wb_dat_ff <= {16'h0000, receive_sequence_counter_ff};
			end
			`OFS_RECEIVE_CONTROL: begin
				wb_dat_ff <= {31'h0000_0000, last_packet_ff};
			end
			default: begin
				wb_dat_ff <= 32'h0000_0000;
			end
			endcase
		end
	end

	// resource low half chosen by the dma
	always_comb begin
		case (resource_sel)
		descriptor_pointer_pkg::res_sel_start: begin
			resource_low = resource_start_address_ff;
		end
		descriptor_pointer_pkg::res_sel_end: begin
			resource_low = resource_end_address_ff;
		end
		descriptor_pointer_pkg::res_sel_read: begin
			resource_low = resource_read_pointer_ff;
		end
		default: begin
			resource_low = resource_write_pointer_ff;
		end
		endcase
	end

	// joined addresses; bit 0 forced low so the list flag never leaks out
	assign dma_addr.transmit_desc = {upper_transmit_pointer_ff,
		current_transmit_pointer_ff[15:1], 1'b0};
	assign dma_addr.receive_desc = {upper_receive_pointer_ff,
		current_receive_pointer_ff[15:1], 1'b0};
	assign dma_addr.resource = {upper_resource_address_ff, resource_low,
		1'b0};
	assign transmit_list_last =
		current_transmit_pointer_ff[`LIST_LAST_BIT];
	assign receive_list_last =
		current_receive_pointer_ff[`LIST_LAST_BIT];
	// equality compares A15:1 only, so write pointer bit 0 never matters
	assign resource_empty =
		(resource_read_pointer_ff == resource_write_pointer_ff);
	assign fetch_resource = fetch_resource_ff;
	assign last_packet_in_buffer_flag = last_packet_ff;
	assign wb_ack_o = wb_ack_ff;
	assign wb_dat_o = wb_dat_ff;

endmodule
